/* logic/crxr_map.vh */
// Purpose: constants for the receive routing and buffer-full pin block
// Assumes: 20 MHz device clock, 1 Mb/s bus bit rate by default
// Notes: offsets are byte addresses of the register access port
`ifndef CRXR_MAP_VH
`define CRXR_MAP_VH
// Register offsets
`define CRXR_ADDR_PINCTRL 8'h0c
`define CRXR_ADDR_BUF0CTRL 8'h60
`define CRXR_ADDR_BUF1CTRL 8'h70
// Reset values
`define CRXR_RST_PINCTRL 8'h00
`define CRXR_RST_BUFCTRL 8'h00
// Pin control fields
`define CRXR_PIN1_STATE 5
`define CRXR_PIN0_STATE 4
`define CRXR_PIN1_EN 3
`define CRXR_PIN0_EN 2
`define CRXR_PIN1_MODE 1
`define CRXR_PIN0_MODE 0
// Buffer control fields
`define CRXR_MODE_HI 6
`define CRXR_MODE_LO 5
`define CRXR_RTR 3
`define CRXR_ROLL 2
`define CRXR_ROLL_COPY 1
`define CRXR_HIT0 0
// Acceptance modes
`define CRXR_ACC_ANY 2'h3
`define CRXR_ACC_EXT 2'h2
`define CRXR_ACC_STD 2'h1
`define CRXR_ACC_BOTH 2'h0
// Message word layout
`define CRXR_MSG_W 9
`define CRXR_MSG_ERR 8
`define CRXR_MSG_RTR 7
`define CRXR_MSG_EXT 6
`define CRXR_FIFO_DEPTH 8
// Buffer 1 code when taken in receive-any mode with no filter hit
`define CRXR_B1_ANY_CODE 3'h2
// Timing
`define CRXR_CLK_NS 50
`define CRXR_BIT_NS 1000
`define CRXR_SAMPLE_NS 750
`define CRXR_IDLE_BITS 11
`define CRXR_SAMPLE_CYC ((`CRXR_SAMPLE_NS + `CRXR_CLK_NS - 1) / `CRXR_CLK_NS)
`define CRXR_IDLE_CYC ((`CRXR_IDLE_BITS * `CRXR_BIT_NS + `CRXR_CLK_NS - 1) / `CRXR_CLK_NS)
`define CRXR_SOF_PULSE_CYC 2
`endif

/* logic/crxr_fifo.v */
// Purpose: message word FIFO between assembly and routing
// Assumes: single clock, synchronous active-low reset
// Notes: outputs a word as soon as one is held
`timescale 1ns/1ps
module crxr_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Fill side
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  // Drain side
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage
  reg [AW-1:0] wrPtr_reg; // Write pointer
  reg [AW-1:0] rdPtr_reg; // Read pointer
  reg [AW:0] count_reg; // Words held
  wire doWrite; // Push this cycle
  wire doRead; // Pop this cycle
  localparam integer LAST_I = DEPTH - 1; // Highest storage index
  localparam [AW:0] FULL_COUNT = DEPTH[AW:0];
  localparam [AW-1:0] LAST_IDX = LAST_I[AW-1:0];

  assign inReady = (count_reg != FULL_COUNT);
  assign outValid = (count_reg != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_reg];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  ////////////////////////////////////////////////////////////////
  // Storage write, no reset needed
  always @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // Pointers and count
  always @(posedge clk) begin
    if (!rstn) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr_reg <= (wrPtr_reg == LAST_IDX) ? {AW{1'b0}} : wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= (rdPtr_reg == LAST_IDX) ? {AW{1'b0}} : rdPtr_reg + 1'b1;
      end
      if (doWrite && !doRead) begin
        count_reg <= count_reg + 1'b1;
      end else if (doRead && !doWrite) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // crxr_fifo

/* logic/crxr_sof_detect.v */
// Purpose: start-of-frame detection with glitch rejection
// Assumes: bus receive pin is asynchronous to clk
// Notes: bus counts as idle after a run of recessive bit times
`timescale 1ns/1ps
`include "crxr_map.vh"
module crxr_sof_detect (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Bus side
  input wire busRxIn,
  // Control and result
  input wire sofEnable,
  output reg sofOut
);
  localparam [1:0] ST_WAIT_IDLE = 2'h0;
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_CHECK = 2'h2;
  localparam integer IDLE_I = `CRXR_IDLE_CYC - 1; // Counts as plain integers
  localparam integer SAMPLE_I = `CRXR_SAMPLE_CYC - 1;
  localparam integer PULSE_I = `CRXR_SOF_PULSE_CYC - 1;
  localparam [7:0] IDLE_LIM = IDLE_I[7:0];
  localparam [7:0] SAMPLE_LIM = SAMPLE_I[7:0];
  localparam [1:0] PULSE_LIM = PULSE_I[1:0];
  reg syncA_reg; // First synchroniser stage
  reg syncB_reg; // Second stage, safe to read
  reg [1:0] state_reg; // Detector state
  reg [7:0] cnt_reg; // Cycle counter
  reg [1:0] pulseCnt_reg; // Pulse width counter

  ////////////////////////////////////////////////////////////////
  // Two-stage synchroniser
  always @(posedge clk) begin
    if (!rstn) begin
      syncA_reg <= 1'b1;
      syncB_reg <= 1'b1;
    end else begin
      syncA_reg <= busRxIn;
      syncB_reg <= syncA_reg;
    end
  end

  // Idle wait, edge watch and sample-point check
  always @(posedge clk) begin
    if (!rstn) begin
      state_reg <= ST_WAIT_IDLE;
      cnt_reg <= 8'h00;
      sofOut <= 1'b0;
      pulseCnt_reg <= 2'h0;
    end else begin
      // Pulse ends after fixed width
      if (sofOut) begin
        if (pulseCnt_reg == PULSE_LIM) begin
          sofOut <= 1'b0;
        end
        pulseCnt_reg <= pulseCnt_reg + 2'h1;
      end
      case (state_reg)
        ST_WAIT_IDLE: begin
          // Dominant restarts the recessive run
          if (!syncB_reg) begin
            cnt_reg <= 8'h00;
          end else if (cnt_reg == IDLE_LIM) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        ST_IDLE: begin
          // Recessive-to-dominant edge on idle bus
          cnt_reg <= 8'h00;
          if (!syncB_reg) begin
            state_reg <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (syncB_reg) begin
            state_reg <= ST_IDLE;
          end else if (cnt_reg == SAMPLE_LIM) begin
            // Dominant held to sample point
            state_reg <= ST_WAIT_IDLE;
            cnt_reg <= 8'h00;
            if (sofEnable) begin
              sofOut <= 1'b1;
              pulseCnt_reg <= 2'h0;
            end
          end else begin
            cnt_reg <= cnt_reg + 8'h01;
          end
        end
        default: begin
          state_reg <= ST_WAIT_IDLE;
        end
      endcase
    end
  end
endmodule // crxr_sof_detect

/* logic/crxr_rx_route.v */
// Purpose: receive buffer routing, filter hit report and full pins
// Assumes: protocol engine supplies one word per assembled message
// Notes: buffer contents move on the loadBuf0/loadBuf1 strobes
//
// Overview of operation
// - Pulse frame-start output per message when enabled
// - Idle bus edge needs dominant to sample point
// - Dominant ending early is a glitch, no pulse
// - Pin enable clear floats full pin
// - Interrupt mode drives pin low on flag
// - Pin returns high once flag cleared
// - Output mode pin follows its state bit
// - State bit reads zero in interrupt mode
// - Two-bit mode selects which messages accepted
// - Read-only bit flags remote request message
// - Rollover sends full buffer 0 message onward
// - Buffer 0 shows read-only rollover copy
// - Buffer 0 hit bit names filter of last buffer 0 or rolled message
// - Buffer 1 hit code names accepting filter
// - Test buffer 0 first, then buffer 1, else discard
// - Full buffer not overwritten, overflow flagged
// - Load sets flag, code and interrupt
// - Receive-any mode keeps errored partial message
`timescale 1ns/1ps
`include "crxr_map.vh"
module crxr_rx_route (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Bus receive pin and frame start
  input wire busRxIn,
  input wire sofEnable,
  output wire sofOut,
  // Assembled message stream
  input wire msgValid,
  output wire msgReady,
  input wire msgErrored,
  input wire msgRemote,
  input wire msgExtended,
  input wire [5:0] msgFilterHit,
  // Register access port
  input wire regWrEn,
  input wire regRdEn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire [7:0] regWrMask,
  output reg [7:0] regRdData,
  // Receive flags and interrupt
  input wire [1:0] rxFlagClear,
  input wire [1:0] rxIrqEnable,
  output wire [1:0] rxLoadedFlag,
  input wire [1:0] overflowClear,
  output wire [1:0] overflowFlag,
  output reg irqOutN,
  // Buffer move strobes
  output reg loadBuf0,
  output reg loadBuf1,
  // Buffer full pins
  output reg buf0FullOut,
  output reg buf0FullOeN,
  output reg buf1FullOut,
  output reg buf1FullOeN
);
  localparam ST_IDLE = 1'b0; // Waiting for a word
  localparam ST_ROUTE = 1'b1; // Routing held word
  localparam [7:0] PIN_RST = `CRXR_RST_PINCTRL; // Pin control reset image

  ////////////////////////////////////////////////////////////////
  // Declarations
  reg state_reg; // Router state
  reg [`CRXR_MSG_W-1:0] msg_reg; // Held message word
  reg [5:0] pinCtrl_reg; // Pin control bits 5..0
  reg [1:0] mode0_reg; // Buffer 0 acceptance mode
  reg [1:0] mode1_reg; // Buffer 1 acceptance mode
  reg roll_reg; // Rollover enable
  reg rtr0_reg; // Buffer 0 remote flag
  reg rtr1_reg; // Buffer 1 remote flag
  reg hit0_reg; // Buffer 0 filter hit
  reg [2:0] hit1_reg; // Buffer 1 filter hit code
  reg [1:0] rxFlag_reg; // Receive loaded flags
  reg [1:0] rxFlag_next;
  reg [1:0] ovr_reg; // Overflow flags
  reg [1:0] ovr_next;
  wire [`CRXR_MSG_W-1:0] fifoData; // Word at FIFO head
  wire fifoValid; // FIFO holds a word
  wire fifoReady; // Router takes a word
  wire wErr; // Held word fields
  wire wRtr;
  wire wExt;
  wire [5:0] wHit;
  reg accept0; // Buffer 0 criteria met
  reg accept1; // Buffer 1 criteria met
  reg hitCode0; // Filter within buffer 0
  reg [2:0] hitCode1; // Filter within buffer 1
  reg set0; // Load into buffer 0
  reg set1; // Load into buffer 1
  reg rolled; // Buffer 0 message to buffer 1
  reg [1:0] ovrSet; // Overflow events
  wire [7:0] pinRead; // Pin control readback
  wire [7:0] buf0Read; // Buffer 0 control readback
  wire [7:0] buf1Read; // Buffer 1 control readback
  wire wrPin; // Write strobes per register
  wire wrBuf0;
  wire wrBuf1;
  wire [5:0] pinMerged; // Bit-modify merged values
  wire [7:0] buf0Merged;
  wire [7:0] buf1Merged;

  ////////////////////////////////////////////////////////////////
  // Frame start detector
  crxr_sof_detect uSof (
    .clk(clk),
    .rstn(rstn),
    .busRxIn(busRxIn),
    .sofEnable(sofEnable),
    .sofOut(sofOut)
  );

  // Message FIFO, stalls upstream only while all 8 entries are held
  crxr_fifo #(
    .WIDTH(`CRXR_MSG_W),
    .DEPTH(`CRXR_FIFO_DEPTH),
    .AW(3)
  ) uFifo (
    .clk(clk),
    .rstn(rstn),
    .inValid(msgValid),
    .inReady(msgReady),
    .inData({msgErrored, msgRemote, msgExtended, msgFilterHit}),
    .outValid(fifoValid),
    .outReady(fifoReady),
    .outData(fifoData)
  );

  // Router only drains in idle
  assign fifoReady = (state_reg == ST_IDLE);
  assign wErr = msg_reg[`CRXR_MSG_ERR];
  assign wRtr = msg_reg[`CRXR_MSG_RTR];
  assign wExt = msg_reg[`CRXR_MSG_EXT];
  assign wHit = msg_reg[5:0];
  assign rxLoadedFlag = rxFlag_reg;
  assign overflowFlag = ovr_reg;

  ////////////////////////////////////////////////////////////////
  // Acceptance per buffer mode
  always @* begin
    // Buffer 0, filters 0 and 1
    hitCode0 = ~wHit[0] & wHit[1];
    case (mode0_reg)
      `CRXR_ACC_ANY: accept0 = 1'b1;
      `CRXR_ACC_EXT: accept0 = !wErr && wExt && (|wHit[1:0]);
      `CRXR_ACC_STD: accept0 = !wErr && !wExt && (|wHit[1:0]);
      default: accept0 = !wErr && (|wHit[1:0]);
    endcase
    // Buffer 1, filters 2..5, lowest number wins
    if (wHit[2]) begin
      hitCode1 = 3'h2;
    end else if (wHit[3]) begin
      hitCode1 = 3'h3;
    end else if (wHit[4]) begin
      hitCode1 = 3'h4;
    end else if (wHit[5]) begin
      hitCode1 = 3'h5;
    end else begin
      hitCode1 = `CRXR_B1_ANY_CODE;
    end
    case (mode1_reg)
      `CRXR_ACC_ANY: accept1 = 1'b1;
      `CRXR_ACC_EXT: accept1 = !wErr && wExt && (|wHit[5:2]);
      `CRXR_ACC_STD: accept1 = !wErr && !wExt && (|wHit[5:2]);
      default: accept1 = !wErr && (|wHit[5:2]);
    endcase
  end

  // Destination choice in priority order
  always @* begin
    set0 = 1'b0;
    set1 = 1'b0;
    rolled = 1'b0;
    ovrSet = 2'h0;
    if (state_reg == ST_ROUTE) begin
      if (accept0) begin
        // Buffer 0 tested first
        if (!rxFlag_reg[0]) begin
          set0 = 1'b1;
        end else if (roll_reg) begin
          // Rollover ignores buffer 1 criteria
          if (!rxFlag_reg[1]) begin
            set1 = 1'b1;
            rolled = 1'b1;
          end else begin
            ovrSet[1] = 1'b1;
          end
        end else begin
          ovrSet[0] = 1'b1;
        end
      end else if (accept1) begin
        if (!rxFlag_reg[1]) begin
          set1 = 1'b1;
        end else begin
          ovrSet[1] = 1'b1;
        end
      end
      // Neither: word dropped
    end
  end

  // Router state
  always @(posedge clk) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      msg_reg <= {`CRXR_MSG_W{1'b0}};
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // Take next word
          if (fifoValid) begin
            msg_reg <= fifoData;
            state_reg <= ST_ROUTE;
          end
        end
        ST_ROUTE: begin
          // One cycle to route, then wait again
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Flag update, a set in the clear cycle wins
  always @* begin
    rxFlag_next = (rxFlag_reg & ~rxFlagClear) | {set1, set0};
    ovr_next = (ovr_reg & ~overflowClear) | ovrSet;
  end

  // Flags, strobes and interrupt output
  always @(posedge clk) begin
    if (!rstn) begin
      rxFlag_reg <= 2'h0;
      ovr_reg <= 2'h0;
      loadBuf0 <= 1'b0;
      loadBuf1 <= 1'b0;
      irqOutN <= 1'b1;
    end else begin
      rxFlag_reg <= rxFlag_next;
      ovr_reg <= ovr_next;
      loadBuf0 <= set0;
      loadBuf1 <= set1;
      // Active-low interrupt while an enabled flag stands
      irqOutN <= ~|(rxFlag_next & rxIrqEnable);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register writes with bit-modify mask
  assign wrPin = regWrEn && (regAddr == `CRXR_ADDR_PINCTRL);
  assign wrBuf0 = regWrEn && (regAddr == `CRXR_ADDR_BUF0CTRL);
  assign wrBuf1 = regWrEn && (regAddr == `CRXR_ADDR_BUF1CTRL);
  // Masked merge lets the host touch single state bits
  assign pinMerged = (pinCtrl_reg & ~regWrMask[5:0]) |
    (regWrData[5:0] & regWrMask[5:0]);
  assign buf0Merged = (buf0Read & ~regWrMask) | (regWrData & regWrMask);
  assign buf1Merged = (buf1Read & ~regWrMask) | (regWrData & regWrMask);

  // Control registers and load-time status
  always @(posedge clk) begin
    if (!rstn) begin
      pinCtrl_reg <= PIN_RST[5:0];
      mode0_reg <= 2'h0;
      mode1_reg <= 2'h0;
      roll_reg <= 1'b0;
      rtr0_reg <= 1'b0;
      rtr1_reg <= 1'b0;
      hit0_reg <= 1'b0;
      hit1_reg <= 3'h0;
    end else begin
      if (wrPin) begin
        pinCtrl_reg <= pinMerged;
      end
      // Only mode and rollover are writable
      if (wrBuf0) begin
        mode0_reg <= buf0Merged[`CRXR_MODE_HI:`CRXR_MODE_LO];
        roll_reg <= buf0Merged[`CRXR_ROLL];
      end
      if (wrBuf1) begin
        mode1_reg <= buf1Merged[`CRXR_MODE_HI:`CRXR_MODE_LO];
      end
      // Buffer 0 load
      if (set0) begin
        rtr0_reg <= wRtr;
        hit0_reg <= hitCode0;
      end
      // Buffer 1 load, rolled codes are 000 or 001
      if (set1) begin
        rtr1_reg <= wRtr;
        if (rolled) begin
          hit1_reg <= {2'h0, hitCode0};
          hit0_reg <= hitCode0;
        end else begin
          hit1_reg <= hitCode1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Readback images
  assign pinRead = {2'h0,
    pinCtrl_reg[`CRXR_PIN1_STATE] & ~pinCtrl_reg[`CRXR_PIN1_MODE],
    pinCtrl_reg[`CRXR_PIN0_STATE] & ~pinCtrl_reg[`CRXR_PIN0_MODE],
    pinCtrl_reg[3:0]};
  assign buf0Read = {1'b0, mode0_reg, 1'b0, rtr0_reg,
    roll_reg, roll_reg, hit0_reg};
  assign buf1Read = {1'b0, mode1_reg, 1'b0, rtr1_reg, hit1_reg};

  // Registered read data, unmapped reads zero
  always @(posedge clk) begin
    if (!rstn) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      case (regAddr)
        `CRXR_ADDR_PINCTRL: regRdData <= pinRead;
        `CRXR_ADDR_BUF0CTRL: regRdData <= buf0Read;
        `CRXR_ADDR_BUF1CTRL: regRdData <= buf1Read;
        default: regRdData <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Buffer full pins, low enable means driven
  always @(posedge clk) begin
    if (!rstn) begin
      buf0FullOut <= 1'b1;
      buf0FullOeN <= 1'b1;
      buf1FullOut <= 1'b1;
      buf1FullOeN <= 1'b1;
    end else begin
      // Disabled pin floats whatever mode says
      buf0FullOeN <= ~pinCtrl_reg[`CRXR_PIN0_EN];
      buf1FullOeN <= ~pinCtrl_reg[`CRXR_PIN1_EN];
      // Buffer 0 pin
      if (pinCtrl_reg[`CRXR_PIN0_MODE]) begin
        buf0FullOut <= ~rxFlag_reg[0];
      end else begin
        buf0FullOut <= pinCtrl_reg[`CRXR_PIN0_STATE];
      end
      // Buffer 1 pin
      if (pinCtrl_reg[`CRXR_PIN1_MODE]) begin
        buf1FullOut <= ~rxFlag_reg[1];
      end else begin
        buf1FullOut <= pinCtrl_reg[`CRXR_PIN1_STATE];
      end
    end
  end
endmodule // crxr_rx_route

/* testbench/crxr_bus_model.sv */
// Purpose: bus receive line model for frames and glitches
// Assumes: recessive is 1 and the line idles recessive
// Notes: a request holds the line dominant for domCyc cycles
`timescale 1ns/1ps
module crxr_bus_model (
  // Clock
  input wire clk,
  // Request from the bench
  input wire frameGo,
  input wire [7:0] domCyc,
  // Bus line
  output wire busRxIn
);
  reg [7:0] cntReg = 8'h00; // Dominant cycles left
  // Load on request, count down otherwise
  always @(posedge clk) begin
    if (frameGo) begin
      cntReg <= domCyc;
    end else if (cntReg != 8'h00) begin
      cntReg <= cntReg - 8'h01;
    end
  end
  // Dominant only while the count runs
  assign busRxIn = (cntReg == 8'h00);
endmodule // crxr_bus_model

/* testbench/crxr_rx_route_checker.sv */
// Purpose: port checks for receive routing and full pins
// Assumes: one clock, synchronous active-low reset
// Notes: shadows the pin control register from write traffic
`timescale 1ns/1ps
module crxr_rx_route_checker (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Bus and frame start
  input wire busRxIn,
  input wire sofEnable,
  input wire sofOut,
  // Register port
  input wire regWrEn,
  input wire regRdEn,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire [7:0] regWrMask,
  input wire [7:0] regRdData,
  // Flags and loads
  input wire [1:0] rxIrqEnable,
  input wire [1:0] rxLoadedFlag,
  input wire [1:0] overflowFlag,
  input wire irqOutN,
  input wire loadBuf0,
  // Full pins
  input wire buf0FullOut,
  input wire buf0FullOeN,
  input wire buf1FullOeN
);
  reg [5:0] pinReg; // Shadow of pin control
  reg [4:0] domCnt; // Run of dominant cycles
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Shadow update with bit-modify mask
  always @(posedge clk) begin
    if (!rstn) begin
      pinReg <= 6'h00;
    end else if (regWrEn && regAddr == 8'h0c) begin
      pinReg <= (pinReg & ~regWrMask[5:0]) | (regWrData[5:0] & regWrMask[5:0]);
    end
  end
  // Saturating count of dominant cycles
  always @(posedge clk) begin
    if (busRxIn) begin
      domCnt <= 5'h00;
    end else if (domCnt != 5'h1f) begin
      domCnt <= domCnt + 5'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_pin0_float: assert property ($past(rstn) |-> buf0FullOeN == !$past(pinReg[2]))
    else $error("pin0 enable mismatch");
  chk_pin1_float: assert property ($past(rstn) |-> buf1FullOeN == !$past(pinReg[3]))
    else $error("pin1 enable mismatch");
  chk_pin_irq_mode: assert property ($past(rstn && pinReg[2] && pinReg[0]) |->
    buf0FullOut == !$past(rxLoadedFlag[0])) else $error("pin0 interrupt level wrong");
  chk_pin_out_mode: assert property ($past(rstn && pinReg[2] && !pinReg[0]) |->
    buf0FullOut == $past(pinReg[4])) else $error("pin0 output level wrong");
  chk_pin_readback: assert property (regRdEn && regAddr == 8'h0c |=> regRdData ==
    {2'b00, $past(pinReg[5] & ~pinReg[1]), $past(pinReg[4] & ~pinReg[0]), $past(pinReg[3:0])})
    else $error("pin control readback wrong");
  chk_sof_width: assert property ($rose(sofOut) |=> sofOut ##1 !sofOut)
    else $error("frame start width wrong");
  chk_sof_cause: assert property ($rose(sofOut) |-> domCnt >= 5'd12 && sofEnable)
    else $error("frame start without held dominant");
  chk_load_sets_flag: assert property (loadBuf0 |-> rxLoadedFlag[0] &&
    !$past(rxLoadedFlag[0])) else $error("buffer 0 load flag wrong");
  chk_load_irq: assert property (loadBuf0 && rxIrqEnable[0] |-> !irqOutN)
    else $error("interrupt missing on load");
  chk_ovf_cause: assert property ($rose(overflowFlag[0]) |-> $past(rxLoadedFlag[0]))
    else $error("overflow with buffer free");
endmodule // crxr_rx_route_checker
bind crxr_rx_route crxr_rx_route_checker crxr_rx_route_checker_inst (.*);

/* testbench/crxr_rx_route_tb.sv */
// Purpose: self-checking bench for receive routing and full pins
// Assumes: 20 MHz clock, inputs driven at the falling edge
// Notes: reads and loads are matched against queued notes
`timescale 1ns/1ps
module crxr_rx_route_tb;
  // Stimulus and observed signals
  reg clk, rstn, sofEnable, msgValid, msgErrored, msgRemote, msgExtended;
  reg regWrEn, regRdEn, frameGo, rdPend, sofPrev, r, acc;
  reg [5:0] msgFilterHit;
  reg [7:0] regAddr, regWrData, regWrMask, domCyc;
  reg [1:0] rxFlagClear, rxIrqEnable, overflowClear;
  wire busRxIn, sofOut, msgReady, irqOutN, loadBuf0, loadBuf1;
  wire buf0FullOut, buf0FullOeN, buf1FullOut, buf1FullOeN;
  wire [7:0] regRdData;
  wire [1:0] rxLoadedFlag, overflowFlag;
  wire [7:0] statBits = {1'b0, irqOutN, overflowFlag, rxLoadedFlag, buf1FullOut, buf0FullOut};
  integer errors, compares, sofRises, fullSeen, i;
  reg [31:0] rngState, tmp;
  reg [7:0] rdQ[$]; // Expected read data
  reg [1:0] ldQ[$]; // Expected load strobes
  crxr_rx_route crxr_rx_route_inst (.*);
  crxr_bus_model crxr_bus_model_inst (.clk(clk), .frameGo(frameGo), .domCyc(domCyc),
    .busRxIn(busRxIn));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Xorshift source
  function logic [31:0] rnd();
    rngState = rngState ^ (rngState << 13);
    rngState = rngState ^ (rngState >> 17);
    rngState = rngState ^ (rngState << 5);
    return rngState;
  endfunction
  // Compare and count
  task chk(input string name, input [7:0] seen, input [7:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask
  // Register write, mask of ones is a plain write
  task wr(input [7:0] a, input [7:0] d, input [7:0] m);
    @(negedge clk);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    regWrMask = m;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask
  // Register read, result noted for the monitor
  task rd(input [7:0] a, input [7:0] e);
    @(negedge clk);
    rdQ.push_back(e);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRdEn = 1'b0;
  endtask
  // One message word, valid held until taken
  task msg(input e, input rr, input x, input [5:0] h, input [1:0] exp);
    @(negedge clk);
    if (exp != 2'b00) ldQ.push_back(exp);
    msgValid = 1'b1;
    msgErrored = e;
    msgRemote = rr;
    msgExtended = x;
    msgFilterHit = h;
    @(posedge clk);
    while (!msgReady) @(posedge clk);
  endtask
  // Drop valid and let routing finish
  task idle;
    @(negedge clk);
    msgValid = 1'b0;
    repeat (10) @(negedge clk);
  endtask
  // Host releases both buffers and overflow flags
  task clr;
    @(negedge clk);
    rxFlagClear = 2'b11;
    overflowClear = 2'b11;
    @(negedge clk);
    rxFlagClear = 2'b00;
    overflowClear = 2'b00;
    repeat (3) @(negedge clk);
  endtask
  // Bus frame or glitch, then idle time
  task frame(input [7:0] n);
    @(negedge clk);
    frameGo = 1'b1;
    domCyc = n;
    @(negedge clk);
    frameGo = 1'b0;
    repeat (320) @(negedge clk);
  endtask
  // Verdict and end of run
  task end_sim;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: oldest note against each read result and load strobe
  always @(posedge clk) begin
    rdPend <= regRdEn;
    sofPrev <= sofOut;
    if (rdPend) chk("read", regRdData, rdQ.pop_front());
    if (loadBuf0 | loadBuf1) begin
      chk("load", {6'h00, loadBuf1, loadBuf0}, {6'h00, ldQ.pop_front()});
    end
    if (sofOut && !sofPrev) sofRises = sofRises + 1;
    if (!msgReady) fullSeen = 1;
  end
  // Watchdog
  initial begin
    #(20000 * 50);
    errors = errors + 1;
    end_sim;
  end
  // Main sequence
  initial begin
    {rstn, sofEnable, msgValid, msgErrored, msgRemote, msgExtended} = 6'h00;
    {regWrEn, regRdEn, frameGo} = 3'h0;
    {msgFilterHit, regAddr, regWrData, regWrMask, domCyc} = 38'h0;
    {rxFlagClear, overflowClear, rxIrqEnable} = 6'h03;
    errors = 0;
    compares = 0;
    sofRises = 0;
    fullSeen = 0;
    rngState = 32'd39716;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    rd(8'h0c, 8'h00);
    rd(8'h60, 8'h00);
    wr(8'h20, 8'hff, 8'hff);
    rd(8'h20, 8'h00);
    wr(8'h60, 8'hff, 8'hff);
    rd(8'h60, 8'h66);
    wr(8'h70, 8'hff, 8'hff);
    rd(8'h70, 8'h60);
    wr(8'h0c, 8'hff, 8'hff);
    rd(8'h0c, 8'h0f);
    wr(8'h0c, 8'h00, 8'h03);
    rd(8'h0c, 8'h3c);
    wr(8'h0c, 8'h00, 8'h10);
    repeat (3) @(negedge clk);
    chk("pins", {4'h0, buf1FullOeN, buf0FullOeN, buf1FullOut, buf0FullOut}, 8'h02);
    wr(8'h0c, 8'h00, 8'h0c);
    repeat (3) @(negedge clk);
    chk("float", {6'h00, buf1FullOeN, buf0FullOeN}, 8'h03);
    // Priority, overflow and interrupt pins
    wr(8'h60, 8'h00, 8'hff);
    wr(8'h70, 8'h00, 8'hff);
    wr(8'h0c, 8'h0f, 8'hff);
    tmp = rnd();
    r = tmp[0];
    msg(1'b0, r, 1'b0, 6'h02, 2'b01);
    msg(1'b0, 1'b0, 1'b1, 6'h08, 2'b10);
    msg(1'b0, 1'b0, 1'b0, 6'h01, 2'b00);
    idle;
    chk("flags", statBits, 8'h1c);
    rd(8'h60, {4'h0, r, 3'b001});
    rd(8'h70, 8'h03);
    clr;
    chk("clear", statBits, 8'h43);
    // Rollover into buffer 1
    wr(8'h60, 8'h04, 8'hff);
    msg(1'b0, 1'b0, 1'b0, 6'h01, 2'b01);
    msg(1'b0, 1'b0, 1'b0, 6'h02, 2'b10);
    msg(1'b0, 1'b0, 1'b0, 6'h01, 2'b00);
    idle;
    chk("ovf", {6'h00, overflowFlag}, 8'h02);
    rd(8'h70, 8'h01);
    rd(8'h60, 8'h07);
    clr;
    // Acceptance modes against identifier kind
    for (i = 0; i < 8; i = i + 1) begin
      wr(8'h60, {1'b0, i[2:1], 5'h00}, 8'hff);
      acc = (i[2:1] == 2'b00) || (i[2:1] == 2'b11) || (i[2:1] == {i[0], ~i[0]});
      msg(1'b0, 1'b0, i[0], 6'h01, {1'b0, acc});
      idle;
      clr;
    end
    msg(1'b1, 1'b0, 1'b0, 6'h00, 2'b01);
    idle;
    clr;
    wr(8'h60, 8'h00, 8'hff);
    msg(1'b1, 1'b0, 1'b0, 6'h01, 2'b00);
    // Random unmatched words fill the queue until it refuses
    for (i = 0; i < 24; i = i + 1) begin
      tmp = rnd();
      msg(tmp[0], tmp[1], tmp[2], 6'h00, 2'b00);
    end
    idle;
    chk("fill", {6'h00, fullSeen[0], msgReady}, 8'h03);
    // Frame start: glitch, frame, then disabled
    sofEnable = 1'b1;
    frame(8'd8);
    frame(8'd60);
    sofEnable = 1'b0;
    frame(8'd60);
    chk("sof", sofRises[7:0], 8'h01);
    chk("left", {7'h00, ldQ.size() != 0}, 8'h00);
    end_sim;
  end
endmodule // crxr_rx_route_tb
